// ### hw/svih_pkg.sv
// package for the single vector interrupt handler: map, fields, states
package svih_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_MOD    = 8;   // peripheral modules; system is bit NUM_MOD
  localparam int NUM_SRC    = NUM_MOD + 1;
  localparam int ADDR_W     = 16;
  localparam int FILT_LEN   = 3;   // undivided clocks a request must hold

  // ****************************************************************
  // register byte offsets on apb
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00; // irq_control_reg
  localparam logic [7:0] OFS_MASK    = 8'h04; // module/system mask
  localparam logic [7:0] OFS_VECTOR  = 8'h08; // service_vector_reg
  localparam logic [7:0] OFS_SRCID   = 8'h0c; // irq_source_id_reg
  localparam logic [7:0] OFS_PREFIX  = 8'h10; // prefix_reg
  localparam logic [7:0] OFS_CLKCFG  = 8'h14; // divider config
  localparam logic [7:0] OFS_FLAGS   = 8'h18; // per module flags, w1c
  localparam logic [7:0] OFS_LOCAL   = 8'h1c; // local source enables

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_GIE_BIT = 0;  // global_irq_enable
  localparam int CTL_INS_BIT = 1;  // in_service_flag
  localparam int CLK_CD_LSB  = 0;  // clock_divide_field, 2 bits
  localparam int CLK_PM_BIT  = 2;  // power_mgmt_enable

  // ****************************************************************
  // reset values and divider counts
  // ****************************************************************
  localparam logic [ADDR_W-1:0] VECTOR_RST = 16'h0000;
  localparam logic [15:0]       PREFIX_RST = 16'h0000;
  localparam logic [1:0]        CD_RST     = 2'h0;
  localparam logic [7:0]        PM_DIV_CNT = 8'hff; // 256 cycles per clock

  // core handshake grouped as one carrier
  typedef struct packed {
    logic              cancel_fetch; // drop next fetch
    logic              push;         // push return address
    logic              load_ip;      // load ip from vector
    logic [ADDR_W-1:0] vector;
  } svih_core_t;

  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_VECTOR} svih_state_t;

endpackage

// ### hw/svih_handler.sv
// single vector interrupt handler with apb register access
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - one interrupt at a time, equal priority, one shared vector
// RULE2 - global enable resets to zero; nothing served until set
// RULE3 - service needs global, module mask and local enable all set
// RULE4 - flags set on any event whatever the enables say
// RULE5 - service routine clears the flag before returning
// RULE6 - source id shows pending bit per module plus shared system bit
// RULE7 - vector register resets to zero, accepts any address
// RULE8 - sample on rising edge, service one cycle later
// RULE9 - cancel fetch, push, set in-service, load vector, run routine
// RULE10 - return pops, clears in-service, reloads ip, resumes
// RULE11 - return not interrupted; ack next cycle, then stall
// RULE12 - async sources pass three sample filter on undivided clock; the code passes the raw pin in stop mode
// RULE13 - latency three, two, one system clocks for divide 1, 2, 4+
// RULE14 - pulses under three undivided clocks are rejected; in stop mode the code passes them unfiltered
// RULE15 - internal sources go straight in, seen within one cycle
// RULE16 - sync and filtered async of one module merge to one request
// RULE17 - enabled external requests wake power management at once
// RULE18 - clearing in-service in software reopens nested servicing
// RULE19 - exception window cycle ignores requests, one cycle later
// RULE20 - prefix write holds one cycle and opens an exception window
// RULE21 - divide field picks 1, 2, 4 or 8 clocks, default 1
// RULE22 - power management gives one system clock per 256
// RULE23 - in-service cleared by reset
module svih_handler
  import svih_pkg::*;
(
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  input  wire logic [7:0]                    PADDR,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire logic [svih_pkg::NUM_SRC-1:0]  SYNC_EVENT,
  input  wire logic [svih_pkg::NUM_SRC-1:0]  ASYNC_EVENT,
  input  wire logic                          STOP_MODE,
  input  wire logic                          RETURN_FROM_IRQ_INSTR,
  input  wire logic [svih_pkg::ADDR_W-1:0]   RETURN_ADDR,
  output svih_pkg::svih_core_t               CORE,
  output logic      [svih_pkg::ADDR_W-1:0]   PUSH_ADDR,
  output logic                               POP,
  output logic      [svih_pkg::ADDR_W-1:0]   RESUME_ADDR,
  output logic                               SYS_CLK_EN,
  output logic      [15:0]                   PREFIX_VALUE,
  output logic                               SWITCHBACK
);
  import svih_pkg::*;

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic                   global_irq_enable;
  logic                   in_service_flag;
  logic [NUM_SRC-1:0]     mask;
  logic [NUM_SRC-1:0]     local_en;
  logic [NUM_SRC-1:0]     flags;
  logic [ADDR_W-1:0]      service_vector_reg;
  logic [15:0]            prefix_reg;
  logic                   prefix_live;
  logic [1:0]             clock_divide_field;
  logic                   power_mgmt_enable;
  logic [7:0]             div_cnt;
  logic [NUM_SRC-1:0]     filt_s1;
  logic [NUM_SRC-1:0]     filt_s2;
  logic [NUM_SRC-1:0]     filt_s3;
  logic [NUM_SRC-1:0]     async_seen;
  logic [NUM_SRC-1:0]     async_hold;
  svih_state_t            state;
  svih_state_t            next_state;

  // apb decode
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wd;
  logic        hit;
  assign wr_en   = PSEL & PENABLE & PWRITE;
  assign rd_en   = PSEL & PENABLE & ~PWRITE;
  assign wd      = PWDATA;
  assign PREADY  = 1'b1;   // zero wait states keeps the core path short
  assign PSLVERR = PSEL & PENABLE & ~hit;

  // exact word match; unaligned or unmapped offsets get the error reply
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign hit = is_reg(PADDR, OFS_CONTROL) | is_reg(PADDR, OFS_MASK) |
               is_reg(PADDR, OFS_VECTOR)  | is_reg(PADDR, OFS_SRCID) |
               is_reg(PADDR, OFS_PREFIX)  | is_reg(PADDR, OFS_CLKCFG) |
               is_reg(PADDR, OFS_FLAGS)   | is_reg(PADDR, OFS_LOCAL);

  // ****************************************************************
  // system clock divider
  // ****************************************************************
  logic [7:0] div_top;
  always_comb begin
    if (power_mgmt_enable) begin
      div_top = PM_DIV_CNT;                         // RULE22
    end else begin
      // ratios are powers of two, so the top count is the ratio less one
      unique case (clock_divide_field)              // RULE21
        2'h0:    div_top = 8'h00;
        2'h1:    div_top = 8'h01;
        2'h2:    div_top = 8'h03;
        2'h3:    div_top = 8'h07;
      endcase
    end
  end

  // free running count; compared, not matched, so a smaller top after
  // a write wraps at once instead of running round all 256 counts
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_cnt <= 8'h00;
    end else if (div_cnt >= div_top) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign SYS_CLK_EN = (div_cnt >= div_top);

  // ****************************************************************
  // async glitch filter on the undivided clock
  // ****************************************************************
  // three aligned samples are needed, so pulses under three clocks die;
  // the and of all three taps is the filtered level
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      filt_s1 <= '0;
      filt_s2 <= '0;
      filt_s3 <= '0;
    end else begin
      filt_s1 <= ASYNC_EVENT;                       // RULE12
      filt_s2 <= filt_s1;
      filt_s3 <= filt_s2;
    end
  end
  // with no running clock in stop mode there is nothing to filter with,
  // so the raw pin is passed through
  assign async_seen = STOP_MODE ? ASYNC_EVENT :
                      (filt_s1 & filt_s2 & filt_s3); // RULE14

  // hold filtered hits until the next system clock enable samples them
  // at divide one the enable is always high and the hold stays empty
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      async_hold <= '0;
    end else if (SYS_CLK_EN) begin
      async_hold <= '0;                             // RULE13
    end else begin
      async_hold <= async_hold | async_seen;
    end
  end

  // wake power management immediately on an enabled external event
  // the filter runs undivided, so no system clock enable is awaited
  assign SWITCHBACK = |(async_seen & local_en & mask); // RULE17

  // ****************************************************************
  // per module flags
  // ****************************************************************
  logic [NUM_SRC-1:0] module_event;
  // one request per module, sync goes straight in
  // a filtered hit is used at once on an enable cycle, else parked
  assign module_event = SYNC_EVENT | ((async_seen | async_hold) &
                        {NUM_SRC{SYS_CLK_EN}});     // RULE15 RULE16

  // set wins over a same-cycle w1c clear
  // write one to clear spares software a read-modify-write race
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      flags <= '0;
    end else if (wr_en && is_reg(PADDR, OFS_FLAGS)) begin
      flags <= (flags & ~wd[NUM_SRC-1:0]) | module_event; // RULE4 RULE5
    end else begin
      flags <= flags | module_event;                // RULE4
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  // enables gate service and the SWITCHBACK wake only and never stop a flag from setting;
  // the vector takes the full address width, any location is legal
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      global_irq_enable  <= 1'b0;                   // RULE2
      mask               <= '0;
      local_en           <= '0;
      service_vector_reg <= VECTOR_RST;             // RULE7
      clock_divide_field <= CD_RST;
      power_mgmt_enable  <= 1'b0;
    end else if (wr_en) begin
      if (is_reg(PADDR, OFS_CONTROL)) begin
        global_irq_enable <= wd[CTL_GIE_BIT];
      end
      if (is_reg(PADDR, OFS_MASK)) begin
        mask <= wd[NUM_SRC-1:0];
      end
      if (is_reg(PADDR, OFS_LOCAL)) begin
        local_en <= wd[NUM_SRC-1:0];
      end
      if (is_reg(PADDR, OFS_VECTOR)) begin
        service_vector_reg <= wd[ADDR_W-1:0];       // RULE7
      end
      if (is_reg(PADDR, OFS_CLKCFG)) begin
        clock_divide_field <= wd[CLK_CD_LSB +: 2];
        power_mgmt_enable  <= wd[CLK_PM_BIT];
      end
    end
  end

  // prefix lives for exactly one cycle after its write
  // cleared after its cycle so a stale prefix never reaches a later op
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prefix_reg  <= PREFIX_RST;
      prefix_live <= 1'b0;
    end else if (wr_en && is_reg(PADDR, OFS_PREFIX)) begin
      prefix_reg  <= wd[15:0];                      // RULE20
      prefix_live <= 1'b1;
    end else begin
      prefix_reg  <= PREFIX_RST;
      prefix_live <= 1'b0;
    end
  end
  assign PREFIX_VALUE = prefix_reg;

  // ****************************************************************
  // service sequencer
  // ****************************************************************
  logic [NUM_SRC-1:0] pending;
  logic               request;
  logic               accept;
  logic               window_hold;
  logic               return_hold;
  // equal priority: any pending source will do, software picks the order
  assign pending = flags & mask & local_en;         // RULE3
  assign request = global_irq_enable & ~in_service_flag & |pending; // RULE1
  // a prefix write opens a window cycle; requests wait it out
  assign window_hold = prefix_live;                 // RULE19
  // the return cycle is never cut; acknowledge follows one cycle on
  assign return_hold = RETURN_FROM_IRQ_INSTR;       // RULE11
  // window cycle and the return cycle both defer acknowledgment
  assign accept  = request & ~window_hold & ~return_hold &
                   SYS_CLK_EN;                      // RULE19 RULE11

  // the stall lets the current instruction finish its own stack access;
  // each step waits for an enable so a call tracks the divided rate
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (accept) next_state = ST_STALL; // RULE8
      ST_STALL:  if (SYS_CLK_EN) next_state = ST_VECTOR;
      ST_VECTOR: if (SYS_CLK_EN) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // in-service: set on vectoring, cleared by return or software
  // a vector step outranks a clear so a call never loses its guard
  logic vec_now;
  assign vec_now = (state == ST_VECTOR) & SYS_CLK_EN;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      in_service_flag <= 1'b0;                      // RULE23
    end else if (vec_now) begin
      in_service_flag <= 1'b1;                      // RULE9
    end else if (RETURN_FROM_IRQ_INSTR && SYS_CLK_EN) begin
      in_service_flag <= 1'b0;                      // RULE10
    end else if (wr_en && is_reg(PADDR, OFS_CONTROL)) begin
      in_service_flag <= wd[CTL_INS_BIT];           // RULE18
    end
  end

  // core takeover outputs come from flops
  // push and ip load share one edge so the core never runs half a call;
  // return address copies run every cycle, the core reads them on strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CORE        <= '0;
      PUSH_ADDR   <= '0;
      POP         <= 1'b0;
      RESUME_ADDR <= '0;
    end else begin
      CORE.cancel_fetch <= (state == ST_STALL) & SYS_CLK_EN;  // RULE9
      CORE.push         <= vec_now;                 // RULE9
      CORE.load_ip      <= vec_now;
      CORE.vector       <= service_vector_reg;
      PUSH_ADDR         <= RETURN_ADDR;
      POP               <= RETURN_FROM_IRQ_INSTR & SYS_CLK_EN; // RULE10
      RESUME_ADDR       <= RETURN_ADDR;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // source id and flag views share bits; only the flag view clears
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (PADDR)
      OFS_CONTROL: rd_word = {30'h0, in_service_flag, global_irq_enable};
      OFS_MASK:    rd_word = {{(32-NUM_SRC){1'b0}}, mask};
      OFS_VECTOR:  rd_word = {16'h0000, service_vector_reg};
      OFS_SRCID:   rd_word = {{(32-NUM_SRC){1'b0}}, flags}; // RULE6
      OFS_PREFIX:  rd_word = {16'h0000, prefix_reg};
      OFS_CLKCFG:  rd_word = {29'h0, power_mgmt_enable, clock_divide_field};
      OFS_FLAGS:   rd_word = {{(32-NUM_SRC){1'b0}}, flags};
      OFS_LOCAL:   rd_word = {{(32-NUM_SRC){1'b0}}, local_en};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  // read data loaded at the setup edge, so it stands through the access
  // cycle with no mux delay on the bus
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rd_word;
    end
  end

endmodule

`default_nettype wire

// ### testbench/svih_checker.sv
// concurrent checks on the interrupt handler ports
`timescale 1ns/1ps
`default_nettype none
module svih_checker
  import svih_pkg::*;
(
  input wire logic                        CLK,
  input wire logic                        RESET,
  input wire logic [7:0]                  PADDR,
  input wire logic                        PSEL,
  input wire logic                        PENABLE,
  input wire logic                        PWRITE,
  input wire logic [31:0]                 PWDATA,
  input wire logic                        PSLVERR,
  input wire logic                        RETURN_FROM_IRQ_INSTR,
  input wire logic [svih_pkg::ADDR_W-1:0] RETURN_ADDR,
  input wire svih_pkg::svih_core_t        CORE,
  input wire logic                        POP,
  input wire logic [svih_pkg::ADDR_W-1:0] RESUME_ADDR,
  input wire logic [15:0]                 PREFIX_VALUE,
  input wire logic                        SYS_CLK_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // push and ip load come together as one vector step
  sequence vec_step_s;
    CORE.push && CORE.load_ip;
  endsequence
  sequence pfx_wr_s;
    PSEL && PENABLE && PWRITE && PADDR == OFS_PREFIX;
  endsequence
  cancel_push_a: assert property (
    CORE.cancel_fetch |=> vec_step_s) else $error("no vector step");
  push_order_a: assert property (
    CORE.push |-> $past(CORE.cancel_fetch)) else $error("push uncancelled");
  one_at_time_a: assert property (
    vec_step_s |=> !CORE.cancel_fetch [*2]) else $error("recursive entry");
  return_from_irq_instr_guard_a: assert property (
    RETURN_FROM_IRQ_INSTR |=> !CORE.cancel_fetch [*2])
    else $error("return cut short");
  pop_after_a: assert property (
    RETURN_FROM_IRQ_INSTR && SYS_CLK_EN |=> POP) else $error("no pop");
  resume_addr_a: assert property (
    POP |-> RESUME_ADDR == $past(RETURN_ADDR)) else $error("bad resume");
  prefix_hold_a: assert property (
    pfx_wr_s |=> PREFIX_VALUE == $past(PWDATA[15:0]) ##1
    PREFIX_VALUE == 16'h0) else $error("prefix not one cycle");
  slverr_map_a: assert property (
    PSEL && PENABLE |-> PSLVERR == (PADDR[1:0] != 2'h0 || PADDR > OFS_LOCAL))
    else $error("bad slverr");
endmodule
bind svih_handler svih_checker svih_checker_i (
  .CLK(CLK), .RESET(RESET), .PADDR(PADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
  .PSLVERR(PSLVERR), .RETURN_FROM_IRQ_INSTR(RETURN_FROM_IRQ_INSTR),
  .RETURN_ADDR(RETURN_ADDR), .CORE(CORE), .POP(POP),
  .RESUME_ADDR(RESUME_ADDR), .PREFIX_VALUE(PREFIX_VALUE),
  .SYS_CLK_EN(SYS_CLK_EN));
`default_nettype wire

// ### testbench/svih_core_model.sv
// behavioural core model: instruction pointer, stack top, return cycle
`timescale 1ns/1ps
`default_nettype none
module svih_core_model
  import svih_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        ret_req,
  input  wire svih_pkg::svih_core_t        core,
  input  wire logic                        pop,
  input  wire logic [svih_pkg::ADDR_W-1:0] push_addr,
  input  wire logic [svih_pkg::ADDR_W-1:0] resume_addr,
  output logic                             ret_instr,
  output logic      [svih_pkg::ADDR_W-1:0] ret_addr,
  output logic      [svih_pkg::ADDR_W-1:0] stacked
);
  logic [ADDR_W-1:0] ip;
  // ip moves every cycle so a stale return address never looks right
  always_ff @(posedge clk or posedge reset) begin
    if (reset) ip <= '0;
    else if (core.load_ip) ip <= core.vector;
    else if (pop) ip <= resume_addr;
    else ip <= ip + 16'h1;
  end
  // one-deep stack: the bench only returns from the outer level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) stacked <= '0;
    else if (core.push) stacked <= push_addr;
  end
  // return instruction lasts one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) ret_instr <= 1'b0;
    else ret_instr <= ret_req;
  end
  assign ret_addr = ret_instr ? stacked : ip;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the interrupt handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import svih_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, stop_mode = 1'b0, ret_req = 1'b0, sb_seen = 1'b0;
  logic [7:0]         paddr = 8'h0;
  logic [31:0]        pwdata = 32'h0, prdata, rdat, perr;
  logic               pready, pslverr, pop, sys_clk_en, switchback, ret_instr;
  logic [NUM_SRC-1:0] sync_ev = '0, async_ev = '0;
  logic [ADDR_W-1:0]  ret_addr, push_addr, resume_addr, stacked, last_vec;
  logic [15:0]        prefix_value;
  svih_core_t         core;
  int                 fail_count, n_checks, svc;
  svih_handler svih_handler_i (
    .CLK(clk), .RESET(reset), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYNC_EVENT(sync_ev), .ASYNC_EVENT(async_ev), .STOP_MODE(stop_mode),
    .RETURN_FROM_IRQ_INSTR(ret_instr), .RETURN_ADDR(ret_addr),
    .CORE(core), .PUSH_ADDR(push_addr), .POP(pop),
    .RESUME_ADDR(resume_addr), .SYS_CLK_EN(sys_clk_en),
    .PREFIX_VALUE(prefix_value), .SWITCHBACK(switchback));
  svih_core_model svih_core_model_i (
    .clk(clk), .reset(reset), .ret_req(ret_req), .core(core), .pop(pop),
    .push_addr(push_addr), .resume_addr(resume_addr),
    .ret_instr(ret_instr), .ret_addr(ret_addr), .stacked(stacked));
  always #50 clk = ~clk;
  // count vector jumps; sampled before the edge's own updates land
  always @(posedge clk) begin
    if (core.load_ip === 1'b1) begin
      svc++;
      last_vec = core.vector;
    end
    if (switchback === 1'b1) sb_seen = 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, the watchdog bounds a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    perr = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ev(input int b, input int n, input logic asy);
    if (asy) async_ev[b] <= 1'b1;
    else sync_ev[b] <= 1'b1;
    idle(n);
    sync_ev <= '0;
    async_ev <= '0;
  endtask
  task automatic wait_svc(input int n);
    repeat (40) if (svc < n) @(posedge clk);
    chk(svc, n);
  endtask
  task automatic cnt_en(input int span, input int exp);
    int c;
    c = 0;
    repeat (span) begin
      @(posedge clk);
      if (sys_clk_en === 1'b1) c++;
    end
    chk(c, exp);
  endtask
  task automatic summarize;
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about 750 cycles of tests; the limit leaves wide margin
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    idle(8);
    reset <= 1'b0;
    rd(OFS_CONTROL, 32'h0);
    rd(OFS_VECTOR, 32'h0);
    rd(8'h20, 32'h0);
    chk(perr, 32'h1);
    wr(OFS_VECTOR, 32'hbeef);
    rd(OFS_VECTOR, 32'hbeef);
    wr(OFS_LOCAL, 32'h1ff);
    wr(OFS_MASK, 32'h1ff);
    ev(2, 1, 1'b0);
    idle(8);
    chk(svc, 0);
    rd(OFS_SRCID, 32'h4);
    wr(OFS_FLAGS, 32'h4);
    rd(OFS_SRCID, 32'h0);
    wr(OFS_MASK, 32'h1f7);
    wr(OFS_CONTROL, 32'h1);
    ev(3, 1, 1'b0);
    idle(8);
    chk(svc, 0);
    wr(OFS_MASK, 32'h1ff);
    wait_svc(1);
    chk(last_vec, 32'hbeef);
    rd(OFS_CONTROL, 32'h3);
    ev(8, 1, 1'b0);
    idle(8);
    chk(svc, 1);
    rd(OFS_SRCID, 32'h108);
    wr(OFS_FLAGS, 32'h8);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    idle(2);
    chk(resume_addr, stacked);
    wait_svc(2);
    wr(OFS_FLAGS, 32'h100);
    ev(0, 1, 1'b0);
    wr(OFS_CONTROL, 32'h1);
    wait_svc(3);
    wr(OFS_FLAGS, 32'h1);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    ev(4, 2, 1'b1);
    idle(4);
    rd(OFS_SRCID, 32'h0);
    ev(4, 3, 1'b1);
    idle(4);
    rd(OFS_SRCID, 32'h10);
    stop_mode <= 1'b1;
    ev(5, 1, 1'b1);
    idle(2);
    rd(OFS_SRCID, 32'h30);
    stop_mode <= 1'b0;
    wr(OFS_PREFIX, 32'h1234);
    @(posedge clk);
    chk(prefix_value, 32'h1234);
    for (int cd = 0; cd < 4; cd++) begin
      wr(OFS_CLKCFG, cd);
      cnt_en(16, 16 >> cd);
    end
    wr(OFS_CLKCFG, 32'h4);
    cnt_en(512, 2);
    wr(OFS_MASK, 32'h1ff);
    ev(6, 3, 1'b1);
    idle(2);
    chk(sb_seen, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
